// ===== rtl/ibc_map.vh
/*
 * Constants for the two-wire bus condition front end.
 * Assumes a 4 ns system clock; all timing counts derive from it.
 */
`ifndef IBC_MAP_VH
`define IBC_MAP_VH

`define IBC_CLK_NS 4
`define IBC_HOLD_SHORT_NS 100
`define IBC_HOLD_LONG_NS 300
`define IBC_HOLD_W 7
`define IBC_HOLD_ZERO 7'h00

`define IBC_ST_W 2
`define IBC_ST_IDLE 2'h0
`define IBC_ST_STARTED 2'h1
`define IBC_ST_RUNNING 2'h2

`define IBC_TEN_HI_PREFIX 5'h1E
`define IBC_RW_BIT 0
`define IBC_ADDR_HI 7
`define IBC_ADDR_LO 1
`define IBC_TEN_A9 2
`define IBC_TEN_A8 1

`define IBC_LINE_IDLE 1'h1
`define IBC_ZERO 1'h0
`define IBC_ONE 1'h1

`endif

// ===== rtl/ibc_sync.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous pin level; output changes only when stages two and three agree.
 */
`timescale 1ns/1ps
module ibc_sync #(
   parameter RESET_LEVEL = 1'h1
) (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_pin,
   output reg o_level
);
   reg s1;
   reg s2;
   reg s3;

   // First stage feeds only the second stage
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1 <= RESET_LEVEL;
         s2 <= RESET_LEVEL;
         s3 <= RESET_LEVEL;
         o_level <= RESET_LEVEL;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule

// ===== rtl/ibc_bus_front.v
/*
 * Bus-level front end of a two-wire serial port: pin takeover, data hold,
 * Start/Stop/Restart detection, collision flags and ten-bit prior-match tracking.
 * Assumes external pull-ups resolve the lines from the enables, and a byte shifter
 * outside supplies address bytes, transmit bits and stretch requests.
 */
// What this block does
// - Enabled port turns clock and data pins into open-drain drivers.
// - Output data toward each pin is always zero; only pull low or release.
// - Data held after clock fall; select bit extends hold to 300 ns.
// - Start: data falls while clock is high.
// - Only masters start; a Start moves bus from idle to active.
// - Issuing Start with data already low flags a collision.
// - Stop: data rises while clock is high.
// - Stop valid only after a clock-low period following the Start.
// - Restart recognised whenever a Stop would be valid.
// - Restart resets slave logic like a Start, awaiting an address byte.
// - Valid ten-bit read re-address holds clock low and prepares data.
// - Prior-match set on full ten-bit write match; cleared by stated events.
// - Bus idle only with both lines high and no master in control.
// - Collision when data reads low while released and expected high.
// - After a read request, slave supplies bytes until Restart or Stop.
// - Address matches only when equal to the slave address register.
// - Anyone may hold clock low; all others wait for release.
// - Data changes only while clock is low; sampled on clock rise.
`timescale 1ns/1ps
`include "ibc_map.vh"
module ibc_bus_front (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_port_enable,
   input wire i_long_hold_select,
   input wire i_scl,
   input wire i_sda,
   input wire i_ten_bit_mode,
   input wire [7:0] i_slave_address_register,
   input wire i_start_req,
   input wire i_tx_drive,
   input wire i_tx_bit,
   input wire i_scl_hold_req,
   input wire i_stretch_release,
   input wire i_addr_strobe,
   input wire [7:0] i_addr_byte,
   output reg o_scl_out,
   output reg o_scl_oe,
   output reg o_sda_out,
   output reg o_sda_oe,
   output reg o_start_det,
   output reg o_stop_det,
   output reg o_restart_det,
   output reg o_slave_reset,
   output reg o_bus_active,
   output reg o_bus_idle,
   output reg o_bus_collision,
   output reg o_addr_match,
   output reg o_prior_match,
   output reg o_read_active,
   output reg o_tx_prepare,
   output reg o_scl_released
);
   localparam integer HOLD_SHORT_CYC =
      (`IBC_HOLD_SHORT_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS;
   localparam integer HOLD_LONG_CYC =
      (`IBC_HOLD_LONG_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS;
   localparam [`IBC_HOLD_W-1:0] HOLD_SHORT = HOLD_SHORT_CYC[`IBC_HOLD_W-1:0];
   localparam [`IBC_HOLD_W-1:0] HOLD_LONG = HOLD_LONG_CYC[`IBC_HOLD_W-1:0];
   localparam [`IBC_ST_W-1:0] ST_IDLE = `IBC_ST_IDLE;
   localparam [`IBC_ST_W-1:0] ST_STARTED = `IBC_ST_STARTED;
   localparam [`IBC_ST_W-1:0] ST_RUNNING = `IBC_ST_RUNNING;

   wire scl_f;
   wire sda_f;
   reg scl_prev;
   reg sda_prev;
   reg [`IBC_ST_W-1:0] bus_state;
   reg [`IBC_ST_W-1:0] next_bus_state;
   reg [`IBC_HOLD_W-1:0] hold_cnt;
   reg sda_low;
   reg start_drive;
   reg await_low;
   reg since_restart;
   reg stretch;

   wire scl_rise;
   wire scl_fall;
   wire sda_rise;
   wire sda_fall;
   wire start_cond;
   wire stop_cond;
   wire restart_cond;
   wire first_start;
   wire hold_done;
   wire hi_match;
   wire low_match;
   wire seven_match;
   wire addr_rw;
   wire expect_high;

   ibc_sync #(.RESET_LEVEL(`IBC_LINE_IDLE)) u_sync_scl (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_pin(i_scl),
      .o_level(scl_f)
   );

   ibc_sync #(.RESET_LEVEL(`IBC_LINE_IDLE)) u_sync_sda (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_pin(i_sda),
      .o_level(sda_f)
   );

   // Edges from consecutive filtered samples
   assign scl_rise = !scl_prev && scl_f;
   assign scl_fall = scl_prev && !scl_f;
   assign sda_rise = !sda_prev && sda_f;
   assign sda_fall = sda_prev && !sda_f;

   // Data moving under a high clock is a bus condition, never data
   assign start_cond = sda_fall && scl_f && scl_prev;
   assign stop_cond = sda_rise && scl_f && scl_prev &&
      (bus_state == ST_RUNNING);
   // A second fall without any clock-low is still only a Start
   assign restart_cond = start_cond && (bus_state == ST_RUNNING);
   assign first_start = start_cond && !restart_cond;

   assign hold_done = (hold_cnt == `IBC_HOLD_ZERO);

   assign addr_rw = i_addr_byte[`IBC_RW_BIT];
   assign seven_match = (i_addr_byte[`IBC_ADDR_HI:`IBC_ADDR_LO] ==
      i_slave_address_register[`IBC_ADDR_HI:`IBC_ADDR_LO]);
   assign hi_match = (i_addr_byte[`IBC_ADDR_HI:`IBC_ADDR_LO] ==
      {`IBC_TEN_HI_PREFIX, i_slave_address_register[`IBC_TEN_A9:`IBC_TEN_A8]});
   assign low_match = (i_addr_byte == i_slave_address_register);

   // Released line that the device wants high
   assign expect_high = !sda_low && ((i_tx_drive && i_tx_bit) || start_drive);

   // Bus state tracking
   always @* begin
      next_bus_state = bus_state;
      case (bus_state)
         ST_IDLE: begin
            if (start_cond) begin
               next_bus_state = ST_STARTED;
            end
         end
         ST_STARTED: begin
            if (!scl_f) begin
               next_bus_state = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (stop_cond) begin
               next_bus_state = ST_IDLE;
            end else if (restart_cond) begin
               next_bus_state = ST_STARTED;
            end
         end
         default: begin
            next_bus_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_prev <= `IBC_LINE_IDLE;
         sda_prev <= `IBC_LINE_IDLE;
         bus_state <= ST_IDLE;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
         if (!i_port_enable) begin
            bus_state <= ST_IDLE;
         end else begin
            bus_state <= next_bus_state;
         end
      end
   end

   // Hold counter restarts on every clock fall
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_cnt <= `IBC_HOLD_ZERO;
      end else if (scl_fall) begin
         hold_cnt <= i_long_hold_select ? HOLD_LONG : HOLD_SHORT;
      end else if (!hold_done) begin
         hold_cnt <= hold_cnt - 1'h1;
      end
   end

   // Data line drive: only pulls low or releases
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sda_low <= `IBC_ZERO;
         start_drive <= `IBC_ZERO;
         o_bus_collision <= `IBC_ZERO;
      end else begin
         o_bus_collision <= `IBC_ZERO;
         if (!i_port_enable) begin
            sda_low <= `IBC_ZERO;
            start_drive <= `IBC_ZERO;
         end else if (start_drive) begin
            // Master Start: hand the line to the shifter after first clock low
            if (scl_fall) begin
               start_drive <= `IBC_ZERO;
            end
         end else if (i_start_req && bus_state == ST_IDLE) begin
            // Line already low before our pull means someone else owns it
            if (!sda_f) begin
               o_bus_collision <= `IBC_ONE;
            end else begin
               sda_low <= `IBC_ONE;
               start_drive <= `IBC_ONE;
            end
         end else if (scl_rise && expect_high && !sda_f) begin
            o_bus_collision <= `IBC_ONE;
            sda_low <= `IBC_ZERO;
         end else if (!scl_f && !scl_fall && hold_done) begin
            // Fall cycle skipped: the counter only reloads on that edge
            sda_low <= i_tx_drive && !i_tx_bit;
         end
      end
   end

   // Slave address tracking and ten-bit prior match
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_addr_match <= `IBC_ZERO;
         o_prior_match <= `IBC_ZERO;
         o_read_active <= `IBC_ZERO;
         o_tx_prepare <= `IBC_ZERO;
         await_low <= `IBC_ZERO;
         since_restart <= `IBC_ZERO;
         stretch <= `IBC_ZERO;
      end else begin
         o_addr_match <= `IBC_ZERO;
         o_tx_prepare <= `IBC_ZERO;
         if (!i_port_enable) begin
            o_prior_match <= `IBC_ZERO;
            o_read_active <= `IBC_ZERO;
            await_low <= `IBC_ZERO;
            since_restart <= `IBC_ZERO;
            stretch <= `IBC_ZERO;
         end else if (stop_cond) begin
            o_prior_match <= `IBC_ZERO;
            o_read_active <= `IBC_ZERO;
            await_low <= `IBC_ZERO;
            since_restart <= `IBC_ZERO;
            stretch <= `IBC_ZERO;
         end else if (start_cond) begin
            // Restart clears the slave as a Start does; since_restart alone records which
            o_read_active <= `IBC_ZERO;
            await_low <= `IBC_ZERO;
            since_restart <= restart_cond;
            stretch <= `IBC_ZERO;
         end else if (i_addr_strobe && await_low) begin
            await_low <= `IBC_ZERO;
            if (low_match) begin
               o_addr_match <= `IBC_ONE;
               o_prior_match <= `IBC_ONE;
            end
         end else if (i_addr_strobe && i_ten_bit_mode) begin
            since_restart <= `IBC_ZERO;
            if (!hi_match) begin
               o_prior_match <= `IBC_ZERO;
            end else if (!addr_rw) begin
               o_prior_match <= `IBC_ZERO;
               await_low <= `IBC_ONE;
            end else if (o_prior_match && since_restart) begin
               // Read only after a full write match and a Restart
               o_addr_match <= `IBC_ONE;
               o_read_active <= `IBC_ONE;
               o_tx_prepare <= `IBC_ONE;
               stretch <= `IBC_ONE;
            end
         end else if (i_addr_strobe) begin
            if (seven_match) begin
               o_addr_match <= `IBC_ONE;
               o_read_active <= addr_rw;
               o_tx_prepare <= addr_rw;
            end
         end else if (stretch && i_stretch_release) begin
            stretch <= `IBC_ZERO;
         end
      end
   end

   // Pin and status outputs, all registered
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_scl_out <= `IBC_ZERO;
         o_sda_out <= `IBC_ZERO;
         o_scl_oe <= `IBC_ZERO;
         o_sda_oe <= `IBC_ZERO;
         o_start_det <= `IBC_ZERO;
         o_stop_det <= `IBC_ZERO;
         o_restart_det <= `IBC_ZERO;
         o_slave_reset <= `IBC_ZERO;
         o_bus_active <= `IBC_ZERO;
         o_bus_idle <= `IBC_ZERO;
         o_scl_released <= `IBC_ZERO;
      end else begin
         // Output value fixed low; the enables alone move the lines
         o_scl_out <= `IBC_ZERO;
         o_sda_out <= `IBC_ZERO;
         o_sda_oe <= i_port_enable && sda_low;
         o_scl_oe <= i_port_enable && (stretch || i_scl_hold_req);
         o_start_det <= i_port_enable && first_start;
         o_stop_det <= i_port_enable && stop_cond;
         o_restart_det <= i_port_enable && restart_cond;
         o_slave_reset <= i_port_enable && start_cond;
         o_bus_active <= i_port_enable && (next_bus_state != ST_IDLE);
         o_bus_idle <= i_port_enable && scl_f && sda_f &&
            (next_bus_state == ST_IDLE);
         // Others stalled on the clock may proceed once the line reads high
         o_scl_released <= scl_f;
      end
   end
endmodule

// ===== test/ibc_bus_front_checker.sv
/* Concurrent checks on the top-level ports of the bus condition front end.
   Assumes it is bound to the design from the testbench top. */
`timescale 1ns/1ps
module ibc_bus_front_checker (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_port_enable,
   input wire i_long_hold_select,
   input wire i_ten_bit_mode,
   input wire o_scl_out,
   input wire o_scl_oe,
   input wire o_sda_out,
   input wire o_sda_oe,
   input wire o_start_det,
   input wire o_stop_det,
   input wire o_restart_det,
   input wire o_slave_reset,
   input wire o_bus_active,
   input wire o_bus_idle,
   input wire o_addr_match,
   input wire o_prior_match,
   input wire o_read_active,
   input wire o_tx_prepare,
   input wire o_scl_released
);
   reg low_seen;
   reg [6:0] since_fall;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // Clock-low seen since the last Start, and cycles since the clock fell
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         low_seen <= 1'h0;
         since_fall <= 7'h00;
      end else begin
         low_seen <= !(o_start_det || o_restart_det) && (low_seen || !o_scl_released);
         if ($fell(o_scl_released)) begin
            since_fall <= 7'h00;
         end else if (since_fall != 7'h7F) begin
            since_fall <= since_fall + 7'h01;
         end
      end
   end
   a_pins_zero: assert property (!o_scl_out && !o_sda_out)
      else $error("pin data not zero");
   a_off_release: assert property (!i_port_enable |=> !o_scl_oe && !o_sda_oe)
      else $error("drive while disabled");
   a_start_high: assert property (o_start_det |-> o_bus_active && !o_bus_idle)
      else $error("bad start state");
   a_stop_low: assert property (o_stop_det |-> low_seen ##1
      (!o_bus_active && !o_prior_match && !o_read_active)) else $error("bad stop");
   a_restart_low: assert property (o_restart_det |-> low_seen && o_slave_reset)
      else $error("bad restart");
   a_reset_cause: assert property (o_slave_reset |-> o_start_det || o_restart_det)
      else $error("stray slave reset");
   a_idle_quiet: assert property (o_bus_idle |-> !o_bus_active)
      else $error("idle while active");
   a_read_stretch: assert property (
      o_tx_prepare && i_ten_bit_mode && i_port_enable |=> o_scl_oe) else $error("no stretch");
   a_prior_set: assert property ($rose(o_prior_match) |-> o_addr_match)
      else $error("prior without match");
   a_hold_time: assert property ($rose(o_sda_oe) && !o_scl_released |->
      since_fall >= (i_long_hold_select ? 7'h49 : 7'h17)) else $error("hold too short");
endmodule

// ===== test/ibc_bus_peer.sv
/* Behavioural peer master on the shared two-wire bus.
   Assumes pull-ups, so a released line reads high; steps are half a link period. */
`timescale 1ns/1ps
module ibc_bus_peer (
   input wire i_scl,
   output reg o_scl_low,
   output reg o_sda_low
);
   initial begin
      o_scl_low = 1'h0;
      o_sda_low = 1'h0;
   end
   // Callers change one line per step; data moves under a high clock only for Start and Stop
   task line(input integer s, input integer d);
      integer k;
      begin
         o_scl_low = (s == 0);
         o_sda_low = (d == 0);
         k = 0;
         // A stretched clock is waited out; bounded so a stuck line cannot hang
         while (s != 0 && !i_scl && k < 200) begin
            #4;
            k = k + 1;
         end
         #40;
      end
   endtask
endmodule

// ===== test/testbench.sv
/* Self-checking bench for the bus condition front end with a peer master.
   Assumes pull-ups on both lines and the checker bound to the design. */
`timescale 1ns/1ps
module testbench;
   reg i_clk_sys = 1'h0, i_rst_b = 1'h0, i_port_enable = 1'h1, i_long_hold_select = 1'h0;
   reg i_ten_bit_mode = 1'h0, i_start_req = 1'h0, i_tx_drive = 1'h0, i_tx_bit = 1'h0;
   reg i_scl_hold_req = 1'h0, i_stretch_release = 1'h0, i_addr_strobe = 1'h0;
   reg [7:0] i_slave_address_register = 8'h00, i_addr_byte = 8'h00, b, sar;
   reg [1:0] e;
   wire o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_start_det, o_stop_det, o_restart_det;
   wire o_slave_reset, o_bus_active, o_bus_idle, o_bus_collision, o_addr_match;
   wire o_prior_match, o_read_active, o_tx_prepare, o_scl_released, p_scl_low, p_sda_low;
   // Pins used as inputs only; each function reads back the line it drives
   wire i_scl = !(o_scl_oe || p_scl_low);
   wire i_sda = !(o_sda_oe || p_sda_low);
   integer errors = 0, compares = 0, seed = 55491, cyc = 0, k, m;
   integer n_st = 0, n_sp = 0, n_rs = 0, n_sr = 0, n_co = 0, n_am = 0, n_tp = 0, x_tp = 0;
   ibc_bus_front dut (
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_port_enable(i_port_enable),
      .i_long_hold_select(i_long_hold_select), .i_scl(i_scl), .i_sda(i_sda),
      .i_ten_bit_mode(i_ten_bit_mode), .i_slave_address_register(i_slave_address_register),
      .i_start_req(i_start_req), .i_tx_drive(i_tx_drive), .i_tx_bit(i_tx_bit),
      .i_scl_hold_req(i_scl_hold_req), .i_stretch_release(i_stretch_release),
      .i_addr_strobe(i_addr_strobe), .i_addr_byte(i_addr_byte),
      .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
      .o_start_det(o_start_det), .o_stop_det(o_stop_det), .o_restart_det(o_restart_det),
      .o_slave_reset(o_slave_reset), .o_bus_active(o_bus_active), .o_bus_idle(o_bus_idle),
      .o_bus_collision(o_bus_collision), .o_addr_match(o_addr_match),
      .o_prior_match(o_prior_match), .o_read_active(o_read_active),
      .o_tx_prepare(o_tx_prepare), .o_scl_released(o_scl_released)
   );
   ibc_bus_peer peer (.i_scl(i_scl), .o_scl_low(p_scl_low), .o_sda_low(p_sda_low));
   always #2 i_clk_sys = !i_clk_sys;
   // Pulses tallied at the falling edge, away from the launching edge
   always @(negedge i_clk_sys) begin
      cyc = cyc + 1;
      n_st = n_st + o_start_det;
      n_sp = n_sp + o_stop_det;
      n_rs = n_rs + o_restart_det;
      n_sr = n_sr + o_slave_reset;
      n_co = n_co + o_bus_collision;
      n_am = n_am + o_addr_match;
      n_tp = n_tp + o_tx_prepare;
      if (cyc == 10000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   function [1:0] exp_addr(input [7:0] a, input [7:0] v);
      exp_addr = {a[7:1] == v[7:1], v[0]};
   endfunction
   function [7:0] hi_byte(input [7:0] a, input rd);
      hi_byte = {5'h1E, a[2:1], rd};
   endfunction
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (exp !== got) begin
            errors = errors + 1;
            $display("wrong value %0s: expected %0h, seen %0h", name, exp, got);
         end
      end
   endtask
   task send_addr(input [7:0] a, input [7:0] v);
      begin
         @(negedge i_clk_sys);
         i_slave_address_register = a;
         i_addr_byte = v;
         i_addr_strobe = 1'h1;
         @(negedge i_clk_sys);
         i_addr_strobe = 1'h0;
         repeat (3) @(negedge i_clk_sys);
      end
   endtask
   task rs;
      begin
         peer.line(0, 0);
         peer.line(0, 1);
         peer.line(1, 1);
         peer.line(1, 0);
         peer.line(0, 0);
      end
   endtask
   task sp;
      begin
         peer.line(0, 0);
         peer.line(1, 0);
         peer.line(1, 1);
      end
   endtask
   task req_start;
      begin
         @(negedge i_clk_sys);
         i_start_req = 1'h1;
         @(negedge i_clk_sys);
         i_start_req = 1'h0;
         repeat (10) @(negedge i_clk_sys);
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst_b = 1'h1;
      repeat (6) @(negedge i_clk_sys);
      chk("idle", 1, o_bus_idle);
      chk("pin data", 0, {o_scl_out, o_sda_out});
      peer.line(1, 0);
      peer.line(1, 1);
      chk("starts", 1, n_st);
      chk("stops", 0, n_sp);
      chk("active", 1, o_bus_active);
      peer.line(0, 1);
      sp;
      chk("stops", 1, n_sp);
      peer.line(1, 0);
      for (k = 0; k < 8; k = k + 1) begin
         sar = $random(seed);
         b = $random(seed);
         if (k[0])
            b[7:1] = sar[7:1];
         m = n_am;
         rs;
         send_addr(sar, b);
         e = exp_addr(sar, b);
         x_tp = x_tp + (e[1] && e[0]);
         chk("match", e[1], n_am - m);
         if (e[1])
            chk("read", e[0], o_read_active);
      end
      chk("restarts", 8, n_rs);
      chk("slave resets", 10, n_sr);
      @(negedge i_clk_sys);
      i_ten_bit_mode = 1'h1;
      sar = $random(seed);
      m = n_am;
      rs;
      send_addr(sar, hi_byte(sar, 1'h0));
      send_addr(sar, sar);
      chk("prior", 1, o_prior_match);
      rs;
      send_addr(sar, hi_byte(sar, 1'h1));
      chk("ten matches", 2, n_am - m);
      chk("stretch", 3, {o_read_active, o_scl_oe});
      chk("prepares", x_tp + 1, n_tp);
      i_stretch_release = 1'h1;
      @(negedge i_clk_sys);
      i_stretch_release = 1'h0;
      repeat (4) @(negedge i_clk_sys);
      chk("released", 0, o_scl_oe);
      rs;
      send_addr(sar, hi_byte(sar ^ 8'h06, 1'h0));
      chk("prior", 0, o_prior_match);
      sp;
      chk("read", 0, o_read_active);
      peer.line(0, 1);
      peer.line(0, 0);
      req_start;
      chk("collisions", 1, n_co);
      peer.line(0, 1);
      peer.line(1, 1);
      @(negedge i_clk_sys);
      i_long_hold_select = $random(seed);
      i_tx_drive = 1'h1;
      m = n_st;
      req_start;
      chk("own start", 1, n_st - m);
      peer.line(0, 1);
      repeat (90) @(negedge i_clk_sys);
      chk("bit drive", 1, o_sda_oe);
      i_tx_bit = 1'h1;
      repeat (90) @(negedge i_clk_sys);
      peer.line(1, 1);
      chk("collisions", 1, n_co);
      i_tx_bit = 1'h0;
      peer.line(0, 1);
      // Inside the hold window the new bit must not reach the line yet
      chk("held bit", 0, o_sda_oe);
      repeat (90) @(negedge i_clk_sys);
      chk("bit drive", 1, o_sda_oe);
      i_tx_bit = 1'h1;
      peer.line(0, 0);
      repeat (90) @(negedge i_clk_sys);
      peer.line(1, 0);
      chk("collisions", 2, n_co);
      @(negedge i_clk_sys);
      i_port_enable = 1'h0;
      repeat (2) @(negedge i_clk_sys);
      chk("disabled", 0, {o_scl_oe, o_sda_oe});
      i_port_enable = 1'h1;
      i_tx_drive = 1'h0;
      peer.line(1, 1);
      chk("clock free", 1, o_scl_released);
      i_scl_hold_req = 1'h1;
      repeat (8) @(negedge i_clk_sys);
      chk("clock held", 2, {o_scl_oe, o_scl_released});
      i_scl_hold_req = 1'h0;
      repeat (8) @(negedge i_clk_sys);
      chk("clock free", 1, o_scl_released);
      tally_and_finish;
   end
endmodule
bind ibc_bus_front ibc_bus_front_checker u_chk (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_port_enable(i_port_enable),
   .i_long_hold_select(i_long_hold_select), .i_ten_bit_mode(i_ten_bit_mode),
   .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_start_det(o_start_det), .o_stop_det(o_stop_det), .o_restart_det(o_restart_det),
   .o_slave_reset(o_slave_reset), .o_bus_active(o_bus_active), .o_bus_idle(o_bus_idle),
   .o_addr_match(o_addr_match), .o_prior_match(o_prior_match),
   .o_read_active(o_read_active), .o_tx_prepare(o_tx_prepare),
   .o_scl_released(o_scl_released)
);
